/* rtl/tad_pkg.sv */
// Constants and types shared by the aperture delay control block
package tad_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 24;
    localparam int DELAY_W = 17;
    localparam int BYTE_W = 8;
    localparam int CAL_CNT_W = 17;
    localparam int RAMP_CNT_W = 8;

    // Register offsets
    localparam logic [9:0] OFS_CAL_ENABLE = 10'h2B0;
    localparam logic [9:0] OFS_CAL_STATUS = 10'h2B2;
    localparam logic [9:0] OFS_DELAY_SETTING = 10'h2B5;
    localparam logic [9:0] OFS_RAMP_CONTROL = 10'h2B8;
    localparam logic [9:0] OFS_IRQ_STATUS = 10'h2BA;
    localparam logic [9:0] OFS_IRQ_CLEAR = 10'h2BB;
    localparam logic [9:0] OFS_IRQ_ENABLE = 10'h2BC;

    // Field positions
    localparam int CAL_EN_BIT = 0;
    localparam int CAL_DONE_BIT = 17;
    localparam int INV_BIT = 16;
    localparam int COARSE_LSB = 8;
    localparam int FINE_LSB = 0;
    localparam int RAMP_EN_BIT = 0;
    localparam int RAMP_RATE_BIT = 1;

    // Reset values
    localparam logic [7:0] CAL_ENABLE_RST = 8'h00;
    localparam logic [23:0] DELAY_SETTING_RST = 24'h000000;
    localparam logic [7:0] RAMP_CONTROL_RST = 8'h00;
    localparam logic [1:0] IRQ_ENABLE_RST = 2'h0;

    // Timing counts in device clocks, ramp step sizes in codes
    localparam logic [7:0] RAMP_INTERVAL_LAST = 8'hFF;
    localparam int APPLY_LIMIT_CYCLES = 1024;
    localparam logic [16:0] CAL_CYCLES_DEFAULT = 17'h13000;
    localparam logic [7:0] STEP_SLOW = 8'h01;
    localparam logic [7:0] STEP_FAST = 8'h04;

    // Interrupt bits
    localparam int IRQ_W = 2;
    localparam int IRQ_CAL_DONE = 0;
    localparam int IRQ_RAMP_DONE = 1;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic invert;
        logic [BYTE_W-1:0] coarse;
        logic [BYTE_W-1:0] fine;
    } delay_word_t;
endpackage

/* rtl/cal_sequencer.sv */
// Calibration sequencer: timed run, result capture, completion flag
`timescale 1ns/1ps
module cal_sequencer #(
    parameter logic [16:0] CAL_CYCLES = tad_pkg::CAL_CYCLES_DEFAULT
) (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic i_enable,
    input wire logic i_start,
    input wire logic [tad_pkg::DELAY_W-1:0] i_measure,
    output logic o_busy,
    output logic o_done,
    output logic o_done_pulse,
    output logic [tad_pkg::DELAY_W-1:0] o_result
);
    typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_FINISHED} cal_state_t;

    cal_state_t state;
    logic [tad_pkg::CAL_CNT_W-1:0] count;
    logic last_cycle;

    assign last_cycle = (count == CAL_CYCLES - 17'h00001);

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= CAL_IDLE;
        end else if (!i_enable) begin
            state <= CAL_IDLE;
        end else begin
            case (state)
                CAL_IDLE: begin
                    if (i_start) begin
                        state <= CAL_RUN;
                    end
                end
                CAL_RUN: begin
                    if (last_cycle) begin
                        state <= CAL_FINISHED;
                    end
                end
                default: begin
                    state <= CAL_FINISHED;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count <= '0;
        end else if (state == CAL_RUN) begin
            count <= count + 17'h00001;
        end else begin
            count <= '0;
        end
    end

    // Result only changes at the end of a run
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_result <= '0;
        end else if (state == CAL_RUN && last_cycle && i_enable) begin
            o_result <= i_measure;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_done_pulse <= 1'b0;
        end else begin
            o_done_pulse <= (state == CAL_RUN) && last_cycle && i_enable;
        end
    end

    assign o_busy = (state == CAL_RUN);
    assign o_done = (state == CAL_FINISHED) && i_enable;
endmodule

/* rtl/aperture_delay_adjust_ctrl.sv */
// Aperture delay control: registers, coarse ramp, calibration select, interrupt
//
// How it works
// - Complete flag only when calibration enabled and finished
// - Status low bits report calibration computed delay
// - Invert bit set inverts device sample clock
// - Manual mode applies coarse field as delay
// - Fine field joins coarse in manual delay
// - Without ramp, new delay within 1024 clocks
// - With ramp, step applied coarse toward written
// - Step one or four codes per 256
// - Calibration mode ignores manual setting register
// - Calibration starts on enable rising edge
`timescale 1ns/1ps
module aperture_delay_adjust_ctrl #(
    parameter logic [16:0] CAL_CYCLES = tad_pkg::CAL_CYCLES_DEFAULT
) (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire tad_pkg::reg_req_t i_req,
    input wire logic [tad_pkg::DELAY_W-1:0] i_cal_measure,
    output logic [tad_pkg::DATA_W-1:0] o_rdata,
    output tad_pkg::delay_word_t o_delay,
    output logic o_ramp_busy,
    output logic o_cal_busy,
    output logic o_irq
);
    typedef enum logic {RAMP_IDLE, RAMP_RUN} ramp_state_t;

    // Register storage
    logic [7:0] cal_enable_reg;
    logic [tad_pkg::DATA_W-1:0] delay_setting;
    logic [7:0] ramp_control;
    logic [tad_pkg::IRQ_W-1:0] irq_status;
    logic [tad_pkg::IRQ_W-1:0] irq_enable;

    // Ramp engine
    ramp_state_t ramp_state;
    logic [tad_pkg::RAMP_CNT_W-1:0] ramp_timer;
    logic [tad_pkg::BYTE_W-1:0] applied_coarse;
    logic [tad_pkg::BYTE_W-1:0] next_coarse;
    logic ramp_done_pulse;

    // Calibration
    logic cal_enable_q;
    logic cal_start;
    logic cal_done;
    logic cal_done_pulse;
    logic cal_busy;
    logic [tad_pkg::DELAY_W-1:0] cal_result;

    // Decoded strobes
    logic wr_cal_enable;
    logic wr_setting;
    logic wr_ramp;
    logic wr_irq_clear;
    logic wr_irq_enable;
    logic [tad_pkg::IRQ_W-1:0] irq_events;
    logic [tad_pkg::IRQ_W-1:0] irq_clear_mask;
    logic [tad_pkg::IRQ_W-1:0] next_irq_status;
    logic [tad_pkg::IRQ_W-1:0] next_irq_enable;

    logic cal_mode;
    logic ramp_en;
    logic ramp_fast;
    logic [tad_pkg::BYTE_W-1:0] coarse_target;
    logic [tad_pkg::BYTE_W-1:0] written_coarse;
    tad_pkg::delay_word_t manual_word;

    function automatic logic hit(input logic [9:0] addr, input logic [9:0] ofs);
        hit = (addr == ofs);
    endfunction

    // Read-bus padding keeps reserved upper bits at zero
    function automatic logic [23:0] pad_byte(input logic [7:0] v);
        pad_byte = {16'h0000, v};
    endfunction

    function automatic logic [23:0] pad_irq(input logic [tad_pkg::IRQ_W-1:0] v);
        pad_irq = {22'h0, v};
    endfunction

    // Moves toward target without overshooting it
    function automatic logic [7:0] step_toward(
        input logic [7:0] cur,
        input logic [7:0] tgt,
        input logic fast
    );
        logic [7:0] step;
        logic [7:0] gap;
        step = fast ? tad_pkg::STEP_FAST : tad_pkg::STEP_SLOW;
        if (tgt > cur) begin
            gap = tgt - cur;
            step_toward = (gap < step) ? tgt : cur + step;
        end else begin
            gap = cur - tgt;
            step_toward = (gap < step) ? tgt : cur - step;
        end
    endfunction

    // Address decoding
    always_comb begin
        wr_cal_enable = 1'b0;
        wr_setting = 1'b0;
        wr_ramp = 1'b0;
        wr_irq_clear = 1'b0;
        wr_irq_enable = 1'b0;
        if (i_req.wr) begin
            if (hit(i_req.addr, tad_pkg::OFS_CAL_ENABLE)) begin
                wr_cal_enable = 1'b1;
            end else if (hit(i_req.addr, tad_pkg::OFS_DELAY_SETTING)) begin
                wr_setting = 1'b1;
            end else if (hit(i_req.addr, tad_pkg::OFS_RAMP_CONTROL)) begin
                wr_ramp = 1'b1;
            end else if (hit(i_req.addr, tad_pkg::OFS_IRQ_CLEAR)) begin
                wr_irq_clear = 1'b1;
            end else if (hit(i_req.addr, tad_pkg::OFS_IRQ_ENABLE)) begin
                wr_irq_enable = 1'b1;
            end
        end
    end

    assign cal_mode = cal_enable_reg[tad_pkg::CAL_EN_BIT];
    assign ramp_en = ramp_control[tad_pkg::RAMP_EN_BIT];
    assign ramp_fast = ramp_control[tad_pkg::RAMP_RATE_BIT];
    assign coarse_target = delay_setting[tad_pkg::COARSE_LSB +: tad_pkg::BYTE_W];
    assign written_coarse = i_req.wdata[tad_pkg::COARSE_LSB +: tad_pkg::BYTE_W];
    // Start pulse lasts exactly one clock after the enable bit rises
    assign cal_start = cal_mode && !cal_enable_q;

    // Control registers; reserved bits are kept as written, except in the interrupt enable register, which stores only its two bits
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cal_enable_reg <= tad_pkg::CAL_ENABLE_RST;
        end else if (wr_cal_enable) begin
            cal_enable_reg <= i_req.wdata[7:0];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            delay_setting <= tad_pkg::DELAY_SETTING_RST;
        end else if (wr_setting) begin
            delay_setting <= i_req.wdata;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ramp_control <= tad_pkg::RAMP_CONTROL_RST;
        end else if (wr_ramp) begin
            ramp_control <= i_req.wdata[7:0];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_enable <= tad_pkg::IRQ_ENABLE_RST;
        end else begin
            irq_enable <= next_irq_enable;
        end
    end

    // Edge detect of the enable bit for the start pulse
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cal_enable_q <= 1'b0;
        end else begin
            cal_enable_q <= cal_mode;
        end
    end

    cal_sequencer #(
        .CAL_CYCLES(CAL_CYCLES)
    ) u_cal_sequencer (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_enable(cal_mode),
        .i_start(cal_start),
        .i_measure(i_cal_measure),
        .o_busy(cal_busy),
        .o_done(cal_done),
        .o_done_pulse(cal_done_pulse),
        .o_result(cal_result)
    );

    // Ramp state machine; a write that lands on the current value needs no ramp
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ramp_state <= RAMP_IDLE;
        end else begin
            case (ramp_state)
                RAMP_IDLE: begin
                    if (wr_setting && ramp_en && written_coarse != applied_coarse) begin
                        ramp_state <= RAMP_RUN;
                    end
                end
                RAMP_RUN: begin
                    if (!ramp_en) begin
                        ramp_state <= RAMP_IDLE;
                    end else if (wr_setting && written_coarse == applied_coarse) begin
                        ramp_state <= RAMP_IDLE;
                    end else if (!wr_setting && ramp_timer == tad_pkg::RAMP_INTERVAL_LAST &&
                                 next_coarse == coarse_target) begin
                        // A write on the last tick retargets, so the ramp must not end here
                        ramp_state <= RAMP_IDLE;
                    end
                end
                default: begin
                    ramp_state <= RAMP_IDLE;
                end
            endcase
        end
    end

    // Interval timer restarts on every coarse write
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ramp_timer <= '0;
        end else if (ramp_state != RAMP_RUN || wr_setting) begin
            ramp_timer <= '0;
        end else begin
            ramp_timer <= ramp_timer + 8'h01;
        end
    end

    assign next_coarse = step_toward(applied_coarse, coarse_target, ramp_fast);

    // Applied coarse code; abrupt update takes one clock, well inside the limit
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            applied_coarse <= '0;
        end else if (!ramp_en) begin
            // Snap whenever the ramp is off, so clearing the enable ends cleanly
            applied_coarse <= coarse_target;
        end else if (ramp_state == RAMP_RUN && ramp_timer == tad_pkg::RAMP_INTERVAL_LAST &&
                     !wr_setting) begin
            applied_coarse <= next_coarse;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ramp_done_pulse <= 1'b0;
        end else begin
            // Event only on reaching the target, never on an abrupt write
            ramp_done_pulse <= ramp_state == RAMP_RUN && ramp_en && !wr_setting &&
                               ramp_timer == tad_pkg::RAMP_INTERVAL_LAST &&
                               next_coarse == coarse_target;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_ramp_busy <= 1'b0;
        end else begin
            o_ramp_busy <= (ramp_state == RAMP_RUN);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_cal_busy <= 1'b0;
        end else begin
            o_cal_busy <= cal_busy;
        end
    end

    // Manual word: invert, applied coarse and fine
    always_comb begin
        manual_word.invert = delay_setting[tad_pkg::INV_BIT];
        manual_word.coarse = applied_coarse;
        manual_word.fine = delay_setting[tad_pkg::FINE_LSB +: tad_pkg::BYTE_W];
    end

    // Calibration result replaces the manual setting entirely
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_delay <= '0;
        end else if (cal_mode) begin
            o_delay <= cal_result;
        end else begin
            o_delay <= manual_word;
        end
    end

    // Sticky events; a new event beats a same-cycle clear
    assign irq_events = {ramp_done_pulse, cal_done_pulse};
    assign irq_clear_mask = wr_irq_clear ? i_req.wdata[tad_pkg::IRQ_W-1:0] : '0;

    // Next interrupt state, shared by the status and the output level
    always_comb begin
        next_irq_status = (irq_status & ~irq_clear_mask) | irq_events;
        next_irq_enable = irq_enable;
        if (wr_irq_enable) begin
            next_irq_enable = i_req.wdata[tad_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_status <= '0;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_irq <= 1'b0;
        end else begin
            // Next values, so the level has no lag behind enable writes
            o_irq <= |(next_irq_status & next_irq_enable);
        end
    end

    // Read data valid in the cycle after the strobe only
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= '0;
        end else if (!i_req.rd) begin
            o_rdata <= '0;
        end else if (hit(i_req.addr, tad_pkg::OFS_CAL_ENABLE)) begin
            o_rdata <= pad_byte(cal_enable_reg);
        end else if (hit(i_req.addr, tad_pkg::OFS_CAL_STATUS)) begin
            o_rdata <= {6'h00, cal_done, cal_result};
        end else if (hit(i_req.addr, tad_pkg::OFS_DELAY_SETTING)) begin
            o_rdata <= delay_setting;
        end else if (hit(i_req.addr, tad_pkg::OFS_RAMP_CONTROL)) begin
            o_rdata <= pad_byte(ramp_control);
        end else if (hit(i_req.addr, tad_pkg::OFS_IRQ_STATUS)) begin
            o_rdata <= pad_irq(irq_status);
        end else if (hit(i_req.addr, tad_pkg::OFS_IRQ_CLEAR)) begin
            o_rdata <= 24'h000000; // Clear register is write-only
        end else if (hit(i_req.addr, tad_pkg::OFS_IRQ_ENABLE)) begin
            o_rdata <= pad_irq(irq_enable);
        end else begin
            o_rdata <= '0;
        end
    end
endmodule

/* dv/tad_monitor.sv */
// Port-level checks of the aperture delay control block
`timescale 1ns/1ps
module tad_monitor #(
    parameter logic [16:0] CAL_CYCLES = tad_pkg::CAL_CYCLES_DEFAULT
) (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire tad_pkg::reg_req_t i_req,
    input wire logic [tad_pkg::DELAY_W-1:0] i_cal_measure,
    input wire logic [tad_pkg::DATA_W-1:0] o_rdata,
    input wire tad_pkg::delay_word_t o_delay,
    input wire logic o_ramp_busy,
    input wire logic o_cal_busy,
    input wire logic o_irq
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_arst_n);

    logic rd_q, busy_q, busy_q2, cal_en, ramp_en, fast;
    logic [9:0] addr_q;
    logic [16:0] last_set;
    logic [7:0] target;
    logic [8:0] gap;
    wire logic wr_set = i_req.wr && i_req.addr == tad_pkg::OFS_DELAY_SETTING;

    // Shadow of the control bits, so checks need no access to internals
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rd_q <= 1'b0;
            busy_q <= 1'b0;
            busy_q2 <= 1'b0;
            cal_en <= 1'b0;
            ramp_en <= 1'b0;
            fast <= 1'b0;
            addr_q <= 10'h000;
            last_set <= 17'h00000;
            target <= 8'h00;
            gap <= 9'h000;
        end else begin
            rd_q <= i_req.rd;
            addr_q <= i_req.addr;
            busy_q <= o_cal_busy;
            busy_q2 <= busy_q;
            if (wr_set) begin
                last_set <= i_req.wdata[16:0];
                target <= i_req.wdata[15:8];
            end
            if (i_req.wr && i_req.addr == tad_pkg::OFS_CAL_ENABLE) begin
                cal_en <= i_req.wdata[0];
            end
            if (i_req.wr && i_req.addr == tad_pkg::OFS_RAMP_CONTROL) begin
                {fast, ramp_en} <= i_req.wdata[1:0];
            end
            gap <= (wr_set || $changed(o_delay.coarse)) ? 9'h000 : gap + 9'h001;
        end
    end

    chk_rdata_idle: assert property (!rd_q |-> o_rdata == 24'h000000)
        else $error("read data not zero outside read slot");
    chk_status_reserved: assert property (
        rd_q && addr_q == tad_pkg::OFS_CAL_STATUS |-> o_rdata[23:18] == 6'h00)
        else $error("status reserved bits not zero");
    chk_done_flag: assert property (
        rd_q && addr_q == tad_pkg::OFS_CAL_STATUS && (!cal_en || o_cal_busy) |-> !o_rdata[17])
        else $error("complete flag set while disabled or running");
    chk_abrupt_apply: assert property (
        wr_set && !ramp_en && !cal_en |=> ##2 o_delay == last_set)
        else $error("manual delay not applied");
    chk_cal_ignores: assert property (
        wr_set && cal_en && !o_cal_busy && !busy_q && !busy_q2 |=> $stable(o_delay) [*2])
        else $error("manual write moved delay in calibration mode");
    chk_cal_start: assert property (
        i_req.wr && i_req.addr == tad_pkg::OFS_CAL_ENABLE && i_req.wdata[0] && !cal_en
        |-> ##[1:4] o_cal_busy)
        else $error("calibration did not start on enable rise");
    chk_ramp_gap: assert property (
        ramp_en && !cal_en && $changed(o_delay.coarse) |-> gap inside {[9'h0FF:9'h102]})
        else $error("ramp step interval wrong");
    chk_ramp_step: assert property (
        ramp_en && !cal_en && $changed(o_delay.coarse) |-> o_delay.coarse == target
        || 8'(o_delay.coarse - $past(o_delay.coarse)) == (fast ? 8'h04 : 8'h01)
        || 8'($past(o_delay.coarse) - o_delay.coarse) == (fast ? 8'h04 : 8'h01))
        else $error("ramp step size wrong");
endmodule

/* dv/tb_top.sv */
// Self-checking bench for the aperture delay control block
`timescale 1ns/1ps
module tb_top;
    // Short calibration run keeps the simulation brief
    localparam logic [16:0] CAL_N = 17'h00014;
    logic i_sys_clk = 1'b0;
    logic i_arst_n = 1'b0;
    tad_pkg::reg_req_t i_req = '0;
    logic [16:0] i_cal_measure = 17'h1ABCD;
    logic [23:0] o_rdata;
    tad_pkg::delay_word_t o_delay;
    logic o_ramp_busy, o_cal_busy, o_irq;
    logic [23:0] rv;
    int fail_count = 0;
    int checks_done = 0;

    aperture_delay_adjust_ctrl #(.CAL_CYCLES(CAL_N)) aperture_delay_adjust_ctrl_inst (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_req(i_req),
        .i_cal_measure(i_cal_measure),
        .o_rdata(o_rdata),
        .o_delay(o_delay),
        .o_ramp_busy(o_ramp_busy),
        .o_cal_busy(o_cal_busy),
        .o_irq(o_irq)
    );

    initial begin
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    task automatic wr(input logic [9:0] a, input logic [23:0] d);
        @(posedge i_sys_clk);
        i_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_sys_clk);
        i_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a);
        @(posedge i_sys_clk);
        i_req <= '{addr: a, wdata: 24'h000000, wr: 1'b0, rd: 1'b1};
        @(posedge i_sys_clk);
        i_req.rd <= 1'b0;
        #1;
        rv = o_rdata;
    endtask

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rchk(input string what, input logic [9:0] a, input logic [23:0] exp);
        rd(a);
        chk(what, exp, rv);
    endtask

    // Waits n edges, then lets that edge's updates settle
    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Whole run needs about 1400 cycles
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        fail_count++;
        conclude();
    end

    initial begin
        repeat (5) @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        rchk("setting rst", tad_pkg::OFS_DELAY_SETTING, 24'h000000);
        rchk("ramp rst", tad_pkg::OFS_RAMP_CONTROL, 24'h000000);
        rchk("cal en rst", tad_pkg::OFS_CAL_ENABLE, 24'h000000);
        rchk("irq en rst", tad_pkg::OFS_IRQ_ENABLE, 24'h000000);
        rchk("unmapped", 10'h2C0, 24'h000000);
        $display("test reset done");

        wr(tad_pkg::OFS_DELAY_SETTING, 24'hFF2A05);
        cyc(3);
        chk("manual delay", 24'h012A05, {7'h00, o_delay});
        rchk("setting rb", tad_pkg::OFS_DELAY_SETTING, 24'hFF2A05);
        $display("test manual done");

        // Slow ramp two codes, then fast ramp nine codes with a clamped last step
        wr(tad_pkg::OFS_RAMP_CONTROL, 24'h000001);
        wr(tad_pkg::OFS_DELAY_SETTING, 24'hFF2C05);
        cyc(250);
        chk("slow hold", 24'h00002A, {16'h0000, o_delay.coarse});
        chk("ramp busy", 24'h000001, {23'h0, o_ramp_busy});
        cyc(10);
        chk("slow step1", 24'h00002B, {16'h0000, o_delay.coarse});
        cyc(256);
        chk("slow step2", 24'h00002C, {16'h0000, o_delay.coarse});
        wr(tad_pkg::OFS_RAMP_CONTROL, 24'h000003);
        wr(tad_pkg::OFS_DELAY_SETTING, 24'hFF3505);
        cyc(260);
        chk("fast step1", 24'h000030, {16'h0000, o_delay.coarse});
        cyc(256);
        chk("fast step2", 24'h000034, {16'h0000, o_delay.coarse});
        cyc(256);
        chk("fast last", 24'h000035, {16'h0000, o_delay.coarse});
        cyc(4);
        chk("ramp idle", 24'h000000, {23'h0, o_ramp_busy});
        $display("test ramp done");

        wr(tad_pkg::OFS_IRQ_ENABLE, 24'h000002);
        cyc(2);
        chk("irq ramp", 24'h000001, {23'h0, o_irq});
        rchk("irq status", tad_pkg::OFS_IRQ_STATUS, 24'h000002);
        wr(tad_pkg::OFS_IRQ_CLEAR, 24'h000002);
        cyc(2);
        chk("irq cleared", 24'h000000, {23'h0, o_irq});
        rchk("irq status clr", tad_pkg::OFS_IRQ_STATUS, 24'h000000);
        $display("test irq done");

        wr(tad_pkg::OFS_RAMP_CONTROL, 24'h000000);
        wr(tad_pkg::OFS_IRQ_ENABLE, 24'h000001);
        wr(tad_pkg::OFS_CAL_ENABLE, 24'h000001);
        rd(tad_pkg::OFS_CAL_STATUS);
        chk("done early", 24'h000000, {23'h0, rv[17]});
        chk("cal busy", 24'h000001, {23'h0, o_cal_busy});
        cyc(40);
        rchk("cal status", tad_pkg::OFS_CAL_STATUS, 24'h03ABCD);
        chk("cal delay", 24'h01ABCD, {7'h00, o_delay});
        chk("irq cal", 24'h000001, {23'h0, o_irq});
        wr(tad_pkg::OFS_DELAY_SETTING, 24'h013344);
        cyc(3);
        chk("cal ignores", 24'h01ABCD, {7'h00, o_delay});
        wr(tad_pkg::OFS_IRQ_ENABLE, 24'h000000);
        cyc(2);
        chk("irq masked", 24'h000000, {23'h0, o_irq});
        wr(tad_pkg::OFS_CAL_ENABLE, 24'h000000);
        cyc(3);
        chk("back manual", 24'h013344, {7'h00, o_delay});
        rd(tad_pkg::OFS_CAL_STATUS);
        chk("done off", 24'h000000, {23'h0, rv[17]});
        rchk("irq pend", tad_pkg::OFS_IRQ_STATUS, 24'h000001);
        wr(tad_pkg::OFS_IRQ_CLEAR, 24'h000001);
        rchk("irq done clr", tad_pkg::OFS_IRQ_STATUS, 24'h000000);
        wr(tad_pkg::OFS_DELAY_SETTING, 24'h013444);
        cyc(3);
        chk("one step", 24'h013444, {7'h00, o_delay});
        $display("test calibration done");
        conclude();
    end
endmodule

bind aperture_delay_adjust_ctrl tad_monitor #(.CAL_CYCLES(CAL_CYCLES)) tad_monitor_inst (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_req(i_req),
    .i_cal_measure(i_cal_measure),
    .o_rdata(o_rdata),
    .o_delay(o_delay),
    .o_ramp_busy(o_ramp_busy),
    .o_cal_busy(o_cal_busy),
    .o_irq(o_irq)
);
